/* File: rtl/timebase_pkg.sv */
// Purpose: Shared constants and types for the periodic timebase.
// Assumes: One 8-bit control register on a plain address/strobe port.
// Notes: Field positions and reset values live here and nowhere else.
package timebase_pkg;

   // Register port widths and the single control register offset.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;
   localparam addr_t CTRL_OFFSET = 4'h0;

   // Control register field positions.
   localparam int FLAG_BIT = 7;
   localparam int TAP_MSB = 6;
   localparam int TAP_LSB = 4;
   localparam int ACK_BIT = 3;
   localparam int IE_BIT = 2;
   localparam int RUN_BIT = 1;

   // Reset values of the stored fields.
   localparam logic CTRL_IE_RESET = 1'h0;
   localparam logic CTRL_RUN_RESET = 1'h0;
   localparam logic [2:0] CTRL_TAP_RESET = 3'h0;
   localparam logic CTRL_FLAG_RESET = 1'h0;
   localparam data_t RDATA_IDLE = 8'h00;

   // Divider structure: optional extra prescale, then the main chain.
   localparam int PRESC_STAGES = 7;
   localparam int CHAIN_STAGES = 15;
   localparam logic [PRESC_STAGES-1:0] PRESC_ONE = 7'h01;
   localparam logic [PRESC_STAGES-1:0] PRESC_MAX = 7'h7f;
   localparam logic [CHAIN_STAGES-1:0] CHAIN_ONE = 15'h0001;

   typedef logic [2:0] tap_sel_t;
   typedef logic [3:0] tap_idx_t;

   // Configuration that steers the divider chain.
   typedef struct packed {
      logic run;
      logic prescale;
      tap_sel_t tap;
   } divider_cfg_s;

   // Chain bit whose rising transition marks a rollover for each tap code.
   function automatic tap_idx_t tap_bit(input tap_sel_t sel);
      case (sel)
         3'h0: tap_bit = 4'he;
         3'h1: tap_bit = 4'hc;
         3'h2: tap_bit = 4'ha;
         3'h3: tap_bit = 4'h6;
         3'h4: tap_bit = 4'h5;
         3'h5: tap_bit = 4'h4;
         3'h6: tap_bit = 4'h3;
         default: tap_bit = 4'h2;
      endcase
   endfunction : tap_bit

endpackage : timebase_pkg

/* File: rtl/ref_clk_sync.sv */
// Purpose: Bring the oscillator reference pin into the core clock domain.
// Assumes: The reference runs well below half the core clock rate.
// Notes: Emits a one-cycle pulse per rising edge of the reference.
`timescale 1ns/1ps
`default_nettype none
module ref_clk_sync (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Asynchronous reference level.
   input wire logic i_osc_reference_clock,
   // Rising edge seen, one cycle.
   output logic o_rise
);

   logic [2:0] sync_q;
   logic level_q;

   // Three-stage shift; only the last two stages are compared.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], i_osc_reference_clock};
      end
   end

   // Accepted level moves only when the second and third stages agree.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         level_q <= 1'h0;
      end else if (sync_q[1] == sync_q[2]) begin
         level_q <= sync_q[2];
      end
   end

   // A rise counts once both late stages read high over a low accepted level.
   assign o_rise = sync_q[1] & sync_q[2] & ~level_q;

endmodule : ref_clk_sync
`default_nettype wire

/* File: rtl/tap_divider_chain.sv */
// Purpose: Optional divide-by-128 prescale followed by a 15-stage chain.
// Assumes: i_tick is one cycle per reference period, already gated.
// Notes: o_event is combinational and marks the selected tap rising.
`timescale 1ns/1ps
`default_nettype none
module tap_divider_chain (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Reference tick and configuration.
   input wire logic i_tick,
   input wire timebase_pkg::divider_cfg_s i_cfg,
   // Rollover event and chain state.
   output logic o_event,
   output logic [timebase_pkg::CHAIN_STAGES-1:0] o_chain
);
   import timebase_pkg::*;

   logic [PRESC_STAGES-1:0] presc_q;
   logic [CHAIN_STAGES-1:0] chain_q;
   logic [CHAIN_STAGES-1:0] chain_d;
   logic src_tick;
   tap_idx_t k;

   // Source tick, next chain value and tap rise detection.
   always_comb begin
      src_tick = i_tick & (~i_cfg.prescale | (presc_q == PRESC_MAX));
      chain_d = chain_q + CHAIN_ONE;
      k = tap_bit(i_cfg.tap);
      // Rising tap bit gives a half period first, then full periods.
      o_event = i_cfg.run & src_tick & ~chain_q[k] & chain_d[k];
   end

   // Extra prescale counts only when selected and running.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         presc_q <= '0;
      end else if (!i_cfg.run || !i_cfg.prescale) begin
         presc_q <= '0;
      end else if (i_tick) begin
         presc_q <= presc_q + PRESC_ONE;
      end
   end

   // Main chain is cleared while stopped and advances per source tick.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         chain_q <= '0;
      end else if (!i_cfg.run) begin
         chain_q <= '0;
      end else if (src_tick) begin
         chain_q <= chain_d;
      end
   end

   assign o_chain = chain_q;

endmodule : tap_divider_chain
`default_nettype wire

/* File: rtl/periodic_timebase_interrupt.sv */
// Purpose: Periodic timebase with one control register and an interrupt.
// Assumes: Wait, stop and configuration options come from core logic.
// Notes: The reference clock pin is sampled, never used as a clock.
// Notes: Tap writes while running are accepted; software must keep them away.
`timescale 1ns/1ps
`default_nettype none
module periodic_timebase_interrupt (
   // Clock and reset.
   input wire logic i_core_clk,
   input wire logic i_rst,

   // Register port.
   input wire timebase_pkg::addr_t i_addr,
   input wire timebase_pkg::data_t i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output timebase_pkg::data_t o_rdata,

   // Oscillator reference pin and configuration options.
   input wire logic i_osc_reference_clock,
   input wire logic i_extra_prescale_select,
   input wire logic i_osc_run_in_stop,

   // Low-power modes.
   input wire logic i_wait_mode,
   input wire logic i_stop_mode,

   // Requests to the processor.
   output logic o_irq,
   output logic o_wakeup
);
   import timebase_pkg::*;

   // Stored control fields and their next values.
   logic ie_q;
   logic run_q;
   tap_sel_t tap_q;
   logic flag_q;
   logic flag_d;
   logic ie_d;

   // Output registers.
   logic irq_q;
   logic wakeup_q;
   data_t rdata_q;

   // Internal strobes and status.
   logic osc_rise;
   logic active;
   logic access_ok;
   logic hit;
   logic wr_ok;
   logic rd_ok;
   logic ack_wr;
   logic div_event;
   divider_cfg_s cfg;
   logic [CHAIN_STAGES-1:0] chain;

   // Reference pin synchroniser.
   ref_clk_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst (i_rst),
      .i_osc_reference_clock (i_osc_reference_clock),
      .o_rise (osc_rise)
   );

   // The oscillator only reaches the chain when it is running.
   assign active = ~i_stop_mode | i_osc_run_in_stop;

   // Configuration seen by the divider chain.
   assign cfg = '{run: run_q, prescale: i_extra_prescale_select, tap: tap_q};

   // Divider chain and tap select.
   tap_divider_chain u_div (
      .i_core_clk (i_core_clk),
      .i_rst (i_rst),
      .i_tick (osc_rise & active),
      .i_cfg (cfg),
      .o_event (div_event),
      .o_chain (chain)
   );

   // The register is unreachable in either low-power mode.
   assign access_ok = ~i_wait_mode & ~i_stop_mode;
   assign hit = (i_addr == CTRL_OFFSET);
   assign wr_ok = i_wr & access_ok & hit;
   assign rd_ok = i_rd & access_ok & hit;
   assign ack_wr = wr_ok & i_wdata[ACK_BIT];

   // Stored fields; the tap may change at any time, software keeps it steady.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         run_q <= CTRL_RUN_RESET;
         tap_q <= CTRL_TAP_RESET;
      end else if (wr_ok) begin
         run_q <= i_wdata[RUN_BIT];
         tap_q <= i_wdata[TAP_MSB:TAP_LSB];
      end
   end

   // Interrupt enable next value.
   always_comb begin
      ie_d = ie_q;
      if (wr_ok) begin
         ie_d = i_wdata[IE_BIT];
      end
   end

   // Pending flag: a new rollover wins over an acknowledge.
   always_comb begin
      flag_d = flag_q;
      if (ack_wr) begin
         flag_d = 1'b0;
      end
      if (div_event) begin
         flag_d = 1'b1;
      end
   end

   // Flag and enable registers; the flag ignores the written flag bit.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_q <= CTRL_FLAG_RESET;
         ie_q <= CTRL_IE_RESET;
      end else begin
         flag_q <= flag_d;
         ie_q <= ie_d;
      end
   end

   // Interrupt and wakeup registered from the next state of flag and enable.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_q <= 1'b0;
         wakeup_q <= 1'b0;
      end else begin
         irq_q <= flag_d & ie_d;
         wakeup_q <= flag_d & ie_d & i_stop_mode & i_osc_run_in_stop;
      end
   end

   // Read data stands for one cycle only; other reads return zero.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= RDATA_IDLE;
      end else if (rd_ok) begin
         rdata_q <= RDATA_IDLE;
         rdata_q[FLAG_BIT] <= flag_q;
         rdata_q[TAP_MSB:TAP_LSB] <= tap_q;
         rdata_q[ACK_BIT] <= 1'b0;
         rdata_q[IE_BIT] <= ie_q;
         rdata_q[RUN_BIT] <= run_q;
      end else begin
         rdata_q <= RDATA_IDLE;
      end
   end

   // Outputs come straight from their registers.
   assign o_irq = irq_q;
   assign o_wakeup = wakeup_q;
   assign o_rdata = rdata_q;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);

   // An acknowledge write arriving alone.
   sequence ack_alone_s;
      ack_wr && !div_event;
   endsequence

   // An acknowledge write meeting a new rollover.
   sequence ack_race_s;
      ack_wr && div_event;
   endsequence

   // A control read, followed by its data cycle.
   sequence ctrl_read_s;
      rd_ok ##1 1'b1;
   endsequence

   flag_set_a:
      assert property (div_event |=> flag_q && o_irq == ie_q)
      else $error("rollover did not set the pending flag");

   irq_tracks_a:
      assert property (o_irq == (ie_q && flag_q))
      else $error("interrupt request does not follow enable and flag");

   ack_clears_a:
      assert property (ack_alone_s |=> !flag_q && !o_irq)
      else $error("acknowledge did not clear the pending flag");

   ack_zero_keeps_a:
      assert property (wr_ok && !i_wdata[ACK_BIT] && flag_q |=> flag_q)
      else $error("writing zero to acknowledge changed the flag");

   ack_reads_zero_a:
      assert property (ctrl_read_s |-> !o_rdata[ACK_BIT]
         && o_rdata[FLAG_BIT] == $past(flag_q))
      else $error("read data wrong in the cycle after a read");

   rdata_idle_a:
      assert property (!rd_ok |=> o_rdata == RDATA_IDLE)
      else $error("read data present without an accepted read");

   wait_blocks_a:
      assert property (i_wr && (i_wait_mode || i_stop_mode)
         |=> $stable(ie_q) && $stable(run_q) && $stable(tap_q))
      else $error("control register written in a low-power mode");

   stop_freeze_a:
      assert property (i_stop_mode && !i_osc_run_in_stop
         |=> $stable(chain) && !$rose(flag_q))
      else $error("timebase moved during stop without oscillator");

   flag_ro_a:
      assert property (wr_ok && i_wdata[FLAG_BIT] && !flag_q && !div_event |=> !flag_q)
      else $error("software write set the pending flag");

   hold_zero_a:
      assert property (!run_q |=> chain == '0 || run_q)
      else $error("chain not held at zero while stopped");

   restart_a:
      assert property ($rose(run_q) |-> chain == '0 ##1 chain <= CHAIN_ONE)
      else $error("chain did not restart from zero");

   set_wins_a:
      assert property (ack_race_s |=> flag_q [*2] or (flag_q ##1 !flag_q))
      else $error("rollover lost during an acknowledge");

   // Further checks on the flag, the outputs and the counting.

   // A reference tick that reaches the chain directly, prescale off.
   sequence direct_tick_s;
      osc_rise && run_q && !i_extra_prescale_select && (!i_stop_mode || i_osc_run_in_stop);
   endsequence

   // Without the enable no request may reach the processor.
   irq_needs_ie_a:
      assert property (!ie_q |-> !o_irq)
      else $error("interrupt request raised while disabled");

   // Only an acknowledge may take the flag down.
   flag_holds_a:
      assert property (flag_q && !ack_wr |=> flag_q)
      else $error("pending flag dropped without an acknowledge");

   // Only a rollover may raise the flag.
   flag_needs_event_a:
      assert property (!flag_q && !div_event |=> !flag_q)
      else $error("pending flag set without a rollover");

   // A stopped chain produces no rollover.
   stopped_quiet_a:
      assert property (!run_q |-> !div_event)
      else $error("rollover while the chain is stopped");

   // Ticks keep the chain moving in wait mode and in stop with the oscillator on.
   tick_advances_a:
      assert property (direct_tick_s |=> chain != $past(chain))
      else $error("chain did not advance on a reference tick");

   // Stored fields read back as they stood at the read.
   rdata_fields_a:
      assert property (ctrl_read_s |-> o_rdata[TAP_MSB:TAP_LSB] == $past(tap_q)
         && o_rdata[IE_BIT] == $past(ie_q) && o_rdata[RUN_BIT] == $past(run_q))
      else $error("read data fields differ from the stored fields");

   // The acknowledge bit never shows on the read data.
   ack_never_reads_a:
      assert property (!o_rdata[ACK_BIT])
      else $error("acknowledge bit seen on the read data");

   // Reads during stop return the idle value.
   stop_no_read_a:
      assert property (i_rd && i_stop_mode |=> o_rdata == RDATA_IDLE)
      else $error("control register read during stop mode");

   // A wakeup needs a request and stop with the oscillator running.
   wakeup_in_stop_a:
      assert property (o_wakeup |-> o_irq && $past(i_stop_mode) && $past(i_osc_run_in_stop))
      else $error("wakeup raised outside stop with the oscillator on");

   // Outside stop mode no wakeup is raised.
   no_wakeup_awake_a:
      assert property (!i_stop_mode |=> !o_wakeup)
      else $error("wakeup raised while not in stop mode");

endmodule : periodic_timebase_interrupt
`default_nettype wire

/* File: dv/periodic_timebase_interrupt_tb_top.sv */
// Purpose: Self-checking bench for the periodic timebase and its control register.
// Assumes: Reference pin toggled by the bench, one rise every 8 core cycles.
// Notes: Taps 0 to 2 without prescale are only read back; taps 0 and 1 are too long for the irq wait limit.
`timescale 1ns/1ps
`default_nettype none
module periodic_timebase_interrupt_tb_top;
   import timebase_pkg::*;

   logic core_clk, rst, wr, rd, presc, run_in_stop, wait_mode, stop_mode, ref_on;
   logic ref_clk = 1'b0;
   addr_t addr;
   data_t wdata, rdata;
   logic irq, wakeup;
   int errors, check_count, n, n0;
   int ref_rises = 0;
   int ref_phase = 0;
   int div_np[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
   int div_p[8] = '{4194304, 1048576, 262144, 16384, 8192, 4096, 2048, 1024};

   periodic_timebase_interrupt u_dut (.i_core_clk(core_clk), .i_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_osc_reference_clock(ref_clk),
      .i_extra_prescale_select(presc), .i_osc_run_in_stop(run_in_stop),
      .i_wait_mode(wait_mode), .i_stop_mode(stop_mode), .o_irq(irq), .o_wakeup(wakeup));

   // Core clock, 50 ns period.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Reference pin: toggles every 4 core cycles while enabled and counts its own rises.
   always @(posedge core_clk) begin
      if (ref_on) begin
         if (ref_phase == 3) begin
            ref_phase <= 0;
            ref_clk <= ~ref_clk;
            if (!ref_clk) ref_rises <= ref_rises + 1;
         end else begin
            ref_phase <= ref_phase + 1;
         end
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   // Compares one value and reports a mismatch at once.
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
   endtask : tick

   // Builds a control byte from its fields.
   function automatic data_t ctl(tap_sel_t t, logic ack, logic ie, logic run);
      return {1'b0, t, ack, ie, run, 1'b0};
   endfunction : ctl

   // One-cycle write strobe.
   task automatic wr_reg(addr_t a, data_t d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg

   // One-cycle read strobe; data judged in the following cycle.
   task automatic rd_reg(addr_t a, data_t exp, string name);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 chk(name, exp, rdata);
   endtask : rd_reg

   // Stops the reference, then restarts the chain with the given tap.
   task automatic start(tap_sel_t t, logic ie);
      ref_on <= 1'b0;
      tick(6);
      wr_reg(CTRL_OFFSET, ctl(t, 1'b1, ie, 1'b0));
      wr_reg(CTRL_OFFSET, ctl(t, 1'b0, ie, 1'b1));
      n0 = ref_rises;
   endtask : start

   // Waits a bounded time for the interrupt; n is the count of rises since n0.
   task automatic wait_irq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 40000) begin
         @(posedge core_clk);
         #1 k++;
      end
      n = ref_rises - n0;
      if (k == 40000) begin
         errors++;
         $display("unexpected timeout waiting irq expected 1 seen %0h", irq);
         print_verdict();
      end
   endtask : wait_irq

   // First interval is half the divider, the next one the full divider.
   task automatic period_test(logic p, int t);
      presc <= p;
      start(tap_sel_t'(t), 1'b1);
      ref_on <= 1'b1;
      wait_irq();
      chk("first interval", (p ? div_p[t] : div_np[t]) / 2, n);
      n0 = ref_rises;
      wr_reg(CTRL_OFFSET, ctl(tap_sel_t'(t), 1'b1, 1'b1, 1'b1));
      #1 chk("irq after ack", 0, irq);
      wait_irq();
      chk("full interval", p ? div_p[t] : div_np[t], n);
   endtask : period_test

   // Reset values, unmapped address and tap field read-back.
   task automatic regs_test();
      rd_reg(CTRL_OFFSET, 8'h00, "ctrl reset");
      chk("irq reset", 0, irq);
      wr_reg(4'h5, 8'h06);
      rd_reg(CTRL_OFFSET, 8'h00, "ctrl after unmapped write");
      rd_reg(4'h5, 8'h00, "unmapped read");
      for (int t = 0; t < 8; t++) begin
         wr_reg(CTRL_OFFSET, ctl(tap_sel_t'(t), 1'b1, 1'b1, 1'b0));
         rd_reg(CTRL_OFFSET, ctl(tap_sel_t'(t), 1'b0, 1'b1, 1'b0), "tap readback");
      end
   endtask : regs_test

   // Flag without enable, acknowledge with zero and with one.
   task automatic flag_test();
      presc <= 1'b0;
      start(3'h7, 1'b0);
      ref_on <= 1'b1;
      tick(45);
      chk("irq disabled", 0, irq);
      rd_reg(CTRL_OFFSET, 8'hf2, "flag pending");
      wr_reg(CTRL_OFFSET, ctl(3'h7, 1'b0, 1'b1, 1'b1));
      #1 chk("irq enabled", 1, irq);
      rd_reg(CTRL_OFFSET, 8'hf6, "flag kept");
      wr_reg(CTRL_OFFSET, 8'hfe);
      rd_reg(CTRL_OFFSET, 8'h76, "flag cleared");
      // Next rollover comes 64 cycles after this one; acknowledge in that cycle.
      wait_irq();
      tick(62);
      wr_reg(CTRL_OFFSET, 8'h7e);
      #1 chk("flag kept on race", 1, irq);
   endtask : flag_test

   // Wait mode keeps counting and refuses register access.
   task automatic wait_test();
      presc <= 1'b0;
      start(3'h7, 1'b1);
      wait_mode <= 1'b1;
      ref_on <= 1'b1;
      wait_irq();
      chk("wait interval", 4, n);
      chk("no wakeup in wait", 0, wakeup);
      rd_reg(CTRL_OFFSET, 8'h00, "read in wait");
      wr_reg(CTRL_OFFSET, 8'h7e);
      tick(1);
      chk("ack in wait", 1, irq);
      wait_mode <= 1'b0;
      wr_reg(CTRL_OFFSET, 8'h7e);
      #1 chk("ack after wait", 0, irq);
   endtask : wait_test

   // Stop mode freezes the chain unless the oscillator runs in stop.
   task automatic stop_test();
      start(3'h7, 1'b1);
      stop_mode <= 1'b1;
      ref_on <= 1'b1;
      tick(320);
      chk("irq frozen", 0, irq);
      rd_reg(CTRL_OFFSET, 8'h00, "read in stop");
      ref_on <= 1'b0;
      tick(6);
      run_in_stop <= 1'b1;
      n0 = ref_rises;
      ref_on <= 1'b1;
      wait_irq();
      chk("stop interval", 4, n);
      tick(2);
      chk("wakeup", 1, wakeup);
      stop_mode <= 1'b0;
      run_in_stop <= 1'b0;
      wr_reg(CTRL_OFFSET, 8'h7e);
      #1 chk("wakeup cleared", 0, wakeup);
   endtask : stop_test

   // Main sequence.
   initial begin
      {rst, wr, rd, presc, run_in_stop, wait_mode, stop_mode, ref_on} = 8'h80;
      addr = 4'h0;
      wdata = 8'h00;
      errors = 0;
      check_count = 0;
      tick(2);
      rst <= 1'b0;
      regs_test();
      flag_test();
      for (int t = 3; t < 8; t++) period_test(1'b0, t);
      period_test(1'b1, 6);
      period_test(1'b1, 7);
      wait_test();
      stop_test();
      print_verdict();
   end
endmodule : periodic_timebase_interrupt_tb_top
`default_nettype wire
